// ==== rtl/pdl_dev_end.sv ====
// device end: coded transmitter, decoder and line selection
`include "pdl_regs.svh"
module pdl_dev_end
    import pdl_pkg::*;
#(
    parameter int HALF  = `PDL_HALF_CYC,
    parameter int CNT_W = `PDL_CNT_W
) (
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    input  wire logic                   ce,
    pdl_link_if.dev                     lnk,
    input  wire logic                   orient_b,
    input  wire logic [`PDL_PEAK_W-1:0] peak_set,
    input  wire logic                   tx_valid,
    input  wire logic                   tx_bit,
    input  wire logic                   tx_last,
    output logic                        tx_ready,
    output logic                        tx_busy,
    output logic                        rx_valid,
    output logic                        rx_bit,
    output logic                        rx_end,
    output logic                        rx_active
);
    // ****************************************************************
    // transmit side
    // ****************************************************************
    pdl_enc_t           enc_st;
    pdl_enc_t           next_enc_st;
    logic [CNT_W-1:0]   cnt;
    logic               lvl;
    logic               next_lvl;
    logic               drive;
    logic               hold_full;
    logic               hold_bit;
    logic               hold_last;
    logic               cur_bit;
    logic               cur_last;
    logic               sel_b;
    logic               a_oe;
    logic               b_oe;
    logic [`PDL_PEAK_W-1:0] peak;
    logic               half_done;
    logic               take;
    logic               load;
    logic               next_hold_full;
    logic               next_drive;
    logic               idle;

    assign half_done = (cnt == CNT_W'(HALF - 1));
    assign idle      = (enc_st == ENC_IDLE);
    assign take      = tx_valid && tx_ready;
    // a new bit enters the shifter at every bit boundary that continues the frame
    assign load      = half_done && ((enc_st == ENC_LEAD) ||
                       ((enc_st == ENC_SECOND) && hold_full && !cur_last));
    assign next_hold_full = take ? 1'b1 : (load ? 1'b0 : hold_full);
    assign next_drive     = (next_enc_st != ENC_IDLE);

    // next state and line level
    always_comb begin
        next_enc_st = enc_st;
        next_lvl    = lvl;
        unique case (enc_st)
            ENC_IDLE: begin
                // never start over a frame already on the line
                if (hold_full && !rx_active) begin
                    next_enc_st = ENC_LEAD;
                    next_lvl    = 1'b0;
                end
            end
            ENC_LEAD: begin
                if (half_done) begin
                    next_enc_st = ENC_FIRST;
                    next_lvl    = ~lvl;
                end
            end
            ENC_FIRST: begin
                if (half_done) begin
                    next_enc_st = ENC_SECOND;
                    next_lvl    = lvl ^ cur_bit;
                end
            end
            ENC_SECOND: begin
                if (half_done) begin
                    // boundary edge doubles as the closing edge on the last bit
                    next_enc_st = load ? ENC_FIRST : ENC_TAIL;
                    next_lvl    = ~lvl;
                end
            end
            ENC_TAIL: begin
                if (half_done)
                    next_enc_st = ENC_IDLE;
            end
            default: begin
                next_enc_st = ENC_IDLE;
                next_lvl    = 1'b1;
            end
        endcase
    end

    // encoder registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            enc_st    <= ENC_IDLE;
            cnt       <= '0;
            lvl       <= 1'b1;
            drive     <= 1'b0;
            hold_full <= 1'b0;
            hold_bit  <= 1'b0;
            hold_last <= 1'b0;
            cur_bit   <= 1'b0;
            cur_last  <= 1'b0;
            tx_ready  <= 1'b0;
            tx_busy   <= 1'b0;
        end else if (ce) begin
            enc_st    <= next_enc_st;
            cnt       <= (idle || half_done) ? '0 : cnt + 1'b1;
            lvl       <= next_lvl;
            drive     <= next_drive;
            hold_full <= next_hold_full;
            tx_ready  <= !next_hold_full && !take;
            tx_busy   <= next_drive;
            if (take) begin
                hold_bit  <= tx_bit;
                hold_last <= tx_last;
            end
            if (load) begin
                cur_bit  <= hold_bit;
                cur_last <= hold_last;
            end
        end
    end

    // ****************************************************************
    // line selection and drive
    // ****************************************************************
    // orientation is followed only while the link is quiet, so a frame never
    // hops lines halfway
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sel_b <= 1'b0;
            a_oe  <= 1'b0;
            b_oe  <= 1'b0;
            peak  <= `PDL_PEAK_RST;
        end else if (ce) begin
            if (idle && !rx_active)
                sel_b <= orient_b;
            a_oe <= next_drive && !sel_b;
            b_oe <= next_drive && sel_b;
            peak <= peak_set;
        end
    end

    assign lnk.config_line_a_out = lvl;
    assign lnk.config_line_b_out = lvl;
    assign lnk.config_line_a_oe  = a_oe;
    assign lnk.config_line_b_oe  = b_oe;
    assign lnk.tx_peak_level     = peak;

    // ****************************************************************
    // receive side
    // ****************************************************************
    logic             s1_a;
    logic             s1_b;
    logic             s2_a;
    logic             s2_b;
    logic             s2;
    logic             s3;
    logic [CNT_W-1:0] gcnt;
    logic             pend;
    logic             edge_seen;
    logic             timeout;
    pdl_iv_t          kind;
    localparam int    GAP = 3 * HALF;

    // the orientation mux reads only synchronised lines
    assign s2        = sel_b ? s2_b : s2_a;
    assign edge_seen = (s2 ^ s3) && idle && !drive;  // own frame is not decoded
    assign timeout   = (gcnt == CNT_W'(GAP));
    assign kind      = pdl_kind(16'(gcnt), 16'(HALF));

    // both lines pass two flops each; first stages feed second stages only
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s1_a <= 1'b1;
            s1_b <= 1'b1;
            s2_a <= 1'b1;
            s2_b <= 1'b1;
            s3   <= 1'b1;
        end else if (ce) begin
            s1_a <= lnk.config_line_a;
            s1_b <= lnk.config_line_b;
            s2_a <= s1_a;
            s2_b <= s1_b;
            s3   <= s2;
        end
    end

    // interval timing and bit recovery
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gcnt      <= '0;
            pend      <= 1'b0;
            rx_active <= 1'b0;
            rx_valid  <= 1'b0;
            rx_bit    <= 1'b0;
            rx_end    <= 1'b0;
        end else if (ce) begin
            rx_valid <= 1'b0;
            rx_end   <= 1'b0;
            if (edge_seen) begin
                gcnt <= '0;
                if (!rx_active || kind == IV_GAP) begin
                    // the first edge, or one after a gap, locks; the interval before it carries no bit
                    rx_active <= 1'b1;
                    pend      <= 1'b0;
                end else if (kind == IV_SHORT) begin
                    pend <= !pend;
                    if (pend) begin
                        rx_valid <= 1'b1;
                        rx_bit   <= 1'b1;
                    end
                end else begin
                    pend     <= 1'b0;
                    rx_valid <= 1'b1;
                    rx_bit   <= 1'b0;
                end
            end else if (timeout) begin
                if (rx_active)
                    rx_end <= 1'b1;
                rx_active <= 1'b0;
                pend      <= 1'b0;
            end else begin
                gcnt <= gcnt + 1'b1;
            end
        end
    end
endmodule // pdl_dev_end

// ==== rtl/pdl_far_end.sv ====
// far end: coded transmitter and decoder on its single attached line
`include "pdl_regs.svh"
module pdl_far_end
    import pdl_pkg::*;
#(
    parameter int HALF  = `PDL_HALF_CYC,
    parameter int CNT_W = `PDL_CNT_W
) (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic ce,
    pdl_link_if.far   lnk,
    input  wire logic tx_valid,
    input  wire logic tx_bit,
    input  wire logic tx_last,
    output logic      tx_ready,
    output logic      tx_busy,
    output logic      rx_valid,
    output logic      rx_bit,
    output logic      rx_end,
    output logic      rx_active
);
    // ****************************************************************
    // transmit side
    // ****************************************************************
    pdl_enc_t         enc_st;
    pdl_enc_t         next_enc_st;
    logic [CNT_W-1:0] cnt;
    logic             lvl;
    logic             next_lvl;
    logic             drive;
    logic             hold_full;
    logic             hold_bit;
    logic             hold_last;
    logic             cur_bit;
    logic             cur_last;
    logic             half_done;
    logic             take;
    logic             load;
    logic             next_hold_full;
    logic             next_drive;
    logic             idle;

    assign half_done = (cnt == CNT_W'(HALF - 1));
    assign idle      = (enc_st == ENC_IDLE);
    assign take      = tx_valid && tx_ready;
    assign load      = half_done && ((enc_st == ENC_LEAD) ||
                       ((enc_st == ENC_SECOND) && hold_full && !cur_last));
    assign next_hold_full = take ? 1'b1 : (load ? 1'b0 : hold_full);
    assign next_drive     = (next_enc_st != ENC_IDLE);

    // next state and line level
    always_comb begin
        next_enc_st = enc_st;
        next_lvl    = lvl;
        unique case (enc_st)
            ENC_IDLE: begin
                if (hold_full && !rx_active) begin
                    next_enc_st = ENC_LEAD;
                    next_lvl    = 1'b0;
                end
            end
            ENC_LEAD: begin
                if (half_done) begin
                    next_enc_st = ENC_FIRST;
                    next_lvl    = ~lvl;
                end
            end
            ENC_FIRST: begin
                if (half_done) begin
                    next_enc_st = ENC_SECOND;
                    next_lvl    = lvl ^ cur_bit;
                end
            end
            ENC_SECOND: begin
                if (half_done) begin
                    next_enc_st = load ? ENC_FIRST : ENC_TAIL;
                    next_lvl    = ~lvl;
                end
            end
            ENC_TAIL: begin
                if (half_done)
                    next_enc_st = ENC_IDLE;
            end
            default: begin
                next_enc_st = ENC_IDLE;
                next_lvl    = 1'b1;
            end
        endcase
    end

    // encoder registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            enc_st    <= ENC_IDLE;
            cnt       <= '0;
            lvl       <= 1'b1;
            drive     <= 1'b0;
            hold_full <= 1'b0;
            hold_bit  <= 1'b0;
            hold_last <= 1'b0;
            cur_bit   <= 1'b0;
            cur_last  <= 1'b0;
            tx_ready  <= 1'b0;
            tx_busy   <= 1'b0;
        end else if (ce) begin
            enc_st    <= next_enc_st;
            cnt       <= (idle || half_done) ? '0 : cnt + 1'b1;
            lvl       <= next_lvl;
            drive     <= next_drive;
            hold_full <= next_hold_full;
            tx_ready  <= !next_hold_full && !take;
            tx_busy   <= next_drive;
            if (take) begin
                hold_bit  <= tx_bit;
                hold_last <= tx_last;
            end
            if (load) begin
                cur_bit  <= hold_bit;
                cur_last <= hold_last;
            end
        end
    end

    assign lnk.far_out = lvl;
    assign lnk.far_oe  = drive;

    // ****************************************************************
    // receive side
    // ****************************************************************
    logic             s1;
    logic             s2;
    logic             s3;
    logic [CNT_W-1:0] gcnt;
    logic             pend;
    logic             edge_seen;
    logic             timeout;
    pdl_iv_t          kind;
    localparam int    GAP = 3 * HALF;

    assign edge_seen = (s2 ^ s3) && idle && !drive;
    assign timeout   = (gcnt == CNT_W'(GAP));
    assign kind      = pdl_kind(16'(gcnt), 16'(HALF));

    // two-stage line synchroniser plus edge stage
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
        end else if (ce) begin
            s1 <= lnk.far_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // interval timing and bit recovery
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gcnt      <= '0;
            pend      <= 1'b0;
            rx_active <= 1'b0;
            rx_valid  <= 1'b0;
            rx_bit    <= 1'b0;
            rx_end    <= 1'b0;
        end else if (ce) begin
            rx_valid <= 1'b0;
            rx_end   <= 1'b0;
            if (edge_seen) begin
                gcnt <= '0;
                if (!rx_active || kind == IV_GAP) begin
                    rx_active <= 1'b1;
                    pend      <= 1'b0;
                end else if (kind == IV_SHORT) begin
                    pend <= !pend;
                    if (pend) begin
                        rx_valid <= 1'b1;
                        rx_bit   <= 1'b1;
                    end
                end else begin
                    pend     <= 1'b0;
                    rx_valid <= 1'b1;
                    rx_bit   <= 1'b0;
                end
            end else if (timeout) begin
                if (rx_active)
                    rx_end <= 1'b1;
                rx_active <= 1'b0;
                pend      <= 1'b0;
            end else begin
                gcnt <= gcnt + 1'b1;
            end
        end
    end
endmodule // pdl_far_end

// ==== rtl/pdl_link_if.sv ====
// shared configuration lines between the device end and the far end
`include "pdl_regs.svh"
interface pdl_link_if;
    logic                    config_line_a_out;
    logic                    config_line_a_oe;
    logic                    config_line_b_out;
    logic                    config_line_b_oe;
    logic [`PDL_PEAK_W-1:0]  tx_peak_level;
    logic                    far_out;
    logic                    far_oe;
    logic                    far_on_b;
    logic                    config_line_a;
    logic                    config_line_b;
    logic                    far_in;

    // undriven lines float back to the dc bias, seen as high
    assign config_line_a = config_line_a_oe ? config_line_a_out :
                           (far_oe && !far_on_b) ? far_out : 1'b1;
    assign config_line_b = config_line_b_oe ? config_line_b_out :
                           (far_oe && far_on_b) ? far_out : 1'b1;
    assign far_in        = far_on_b ? config_line_b : config_line_a;

    modport dev (
        output config_line_a_out,
        output config_line_a_oe,
        output config_line_b_out,
        output config_line_b_oe,
        output tx_peak_level,
        input  config_line_a,
        input  config_line_b
    );
    modport far (
        output far_out,
        output far_oe,
        input  far_in
    );
endinterface

// ==== rtl/pdl_pkg.sv ====
// types and shared decode function of the baseband coded link
`include "pdl_regs.svh"
package pdl_pkg;
    // ****************************************************************
    // encoder states, one-hot
    // ****************************************************************
    typedef enum logic [4:0] {
        ENC_IDLE   = 5'h01,
        ENC_LEAD   = 5'h02,
        ENC_FIRST  = 5'h04,
        ENC_SECOND = 5'h08,
        ENC_TAIL   = 5'h10
    } pdl_enc_t;

    typedef enum logic [2:0] {
        IV_SHORT = 3'h1,
        IV_LONG  = 3'h2,
        IV_GAP   = 3'h4
    } pdl_iv_t;

    // ****************************************************************
    // edge interval classification
    // ****************************************************************
    // thresholds sit midway between nominal half, full and idle gaps
    function automatic pdl_iv_t pdl_kind(input logic [15:0] len, input logic [15:0] half);
        pdl_iv_t k;
        k = IV_GAP;
        if (len < half + (half >> 1))
            k = IV_SHORT;
        else if (len < (half << 1) + (half >> 1))
            k = IV_LONG;
        return k;
    endfunction
endpackage

// ==== rtl/pdl_regs.svh ====
// timing counts and field constants of the baseband coded link
`ifndef PDL_REGS_SVH
`define PDL_REGS_SVH
// ****************************************************************
// timing
// ****************************************************************
`define PDL_CLK_NS   10
`define PDL_UI_NS    3333
`define PDL_HALF_CYC (`PDL_UI_NS / (2 * `PDL_CLK_NS))
`define PDL_CNT_W    10
// ****************************************************************
// transmit level setting
// ****************************************************************
`define PDL_PEAK_W   4
`define PDL_PEAK_RST 4'h8
`endif

// ==== tb/pd_bmc_phy_link_tb.sv ====
// self-checking bench: device end and far end joined over the shared lines
`include "pdl_regs.svh"
module pd_bmc_phy_link_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // stimulus and wiring
    // ****************************************************************
    localparam int HALF = 8;
    logic                   core_clk = 1'b0;
    logic                   rst = 1'b1;
    logic                   ce = 1'b1;
    logic                   orient_b = 1'b0;
    logic                   far_on_b = 1'b0;
    logic [`PDL_PEAK_W-1:0] peak_set = `PDL_PEAK_RST;
    logic [1:0]             tv = 2'h0;
    logic [1:0]             tbit = 2'h0;
    logic [1:0]             tl = 2'h0;
    wire  [1:0]             rdy, busy, rxv, rxb, rxe, rxa;
    logic [31:0]            got [2];
    int                     gn [2];
    int                     ends [2];
    int                     mismatches = 0;
    int                     check_count = 0;

    pdl_link_if lk ();
    assign lk.far_on_b = far_on_b;

    // index 0 is the device end, index 1 the far end
    pdl_dev_end #(.HALF(HALF)) i_pdl_dev_end (.core_clk(core_clk), .rst(rst), .ce(ce),
        .lnk(lk), .orient_b(orient_b), .peak_set(peak_set), .tx_valid(tv[0]),
        .tx_bit(tbit[0]), .tx_last(tl[0]), .tx_ready(rdy[0]), .tx_busy(busy[0]),
        .rx_valid(rxv[0]), .rx_bit(rxb[0]), .rx_end(rxe[0]), .rx_active(rxa[0]));
    pdl_far_end #(.HALF(HALF)) i_pdl_far_end (.core_clk(core_clk), .rst(rst), .ce(ce),
        .lnk(lk), .tx_valid(tv[1]), .tx_bit(tbit[1]), .tx_last(tl[1]), .tx_ready(rdy[1]),
        .tx_busy(busy[1]), .rx_valid(rxv[1]), .rx_bit(rxb[1]), .rx_end(rxe[1]),
        .rx_active(rxa[1]));
    pdl_link_sva #(.HALF(HALF)) i_pdl_link_sva (.core_clk(core_clk), .rst(rst),
        .config_line_a_out(lk.config_line_a_out), .config_line_a_oe(lk.config_line_a_oe),
        .config_line_b_out(lk.config_line_b_out), .config_line_b_oe(lk.config_line_b_oe),
        .far_out(lk.far_out), .far_oe(lk.far_oe), .far_on_b(lk.far_on_b));

    always #5 core_clk = ~core_clk;

    // decoded bits shift in msb first, so the word reads like the sent pattern
    always @(posedge core_clk) begin
        for (int s = 0; s < 2; s++) begin
            if (rxv[s] === 1'b1) begin
                got[s] <= {got[s][30:0], rxb[s]};
                gn[s]  <= gn[s] + 1;
            end
            if (rxe[s] === 1'b1) begin
                ends[s] <= ends[s] + 1;
            end
        end
    end

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic check(input logic [31:0] got_v, input logic [31:0] exp_v);
        check_count++;
        if (got_v !== exp_v) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got_v, exp_v);
        end
    endtask

    // valid stays up across the frame so it is never lowered and raised in one step
    task automatic send(input int s, input logic [15:0] p, input int n);
        int k;
        for (int i = n - 1; i >= 0; i--) begin
            tv[s]   <= 1'b1;
            tbit[s] <= p[i];
            tl[s]   <= (i == 0);
            k = 0;
            do begin
                @(posedge core_clk);
                k++;
            end while (rdy[s] !== 1'b1 && k < 2000);
        end
        tv[s] <= 1'b0;
        tl[s] <= 1'b0;
    endtask

    // rx_n is what the far side decodes: all n bits when it hears the lead
    // edge, fewer when it joins late, none when it listens on the other line
    task automatic frame(input int s, input logic [15:0] p, input int n, input int rx_n);
        int d;
        int k;
        d = 1 - s;
        got[d]  = 32'h0;
        gn[d]   = 0;
        ends[d] = 0;
        send(s, p, n);
        k = 0;
        while ((busy[s] !== 1'b0 || rxa[d] !== 1'b0) && k < 2000) begin
            @(posedge core_clk);
            k++;
        end
        repeat (2) @(posedge core_clk);
        check({busy[s], rxa[d]}, 2'h0);
        check(gn[d], rx_n);
        check(got[d], p & ((32'h1 << rx_n) - 1));
        check(ends[d], (rx_n > 0));
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset;
        check(lk.tx_peak_level, `PDL_PEAK_RST);
        check({lk.config_line_a_oe, lk.config_line_b_oe, lk.far_oe}, 3'h0);
        // a low clock enable must keep the old level
        ce       <= 1'b0;
        peak_set <= 4'h3;
        repeat (2) @(posedge core_clk);
        check(lk.tx_peak_level, `PDL_PEAK_RST);
        ce       <= 1'b1;
        repeat (2) @(posedge core_clk);
        check(lk.tx_peak_level, 4'h3);
        $display("test reset and peak level done");
    endtask

    task automatic t_line_a;
        frame(0, 16'hB38D, 16, 16);
        check({lk.config_line_a, lk.config_line_b}, 2'h3);
        frame(0, 16'h0000, 8, 8);
        frame(0, 16'h00FF, 8, 8);
        $display("test device to far on line a done");
    endtask

    task automatic t_orient;
        orient_b <= 1'b1;
        far_on_b <= 1'b1;
        repeat (2) @(posedge core_clk);
        frame(0, 16'h6A5F, 16, 16);
        far_on_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        frame(0, 16'h0F0F, 12, 0);
        // far side joins line b while it is high after the first boundary, so the
        // lead edge is lost and it locks on the boundary of the second bit
        fork
            frame(0, 16'h03A5, 12, 11);
            begin
                repeat (16) @(posedge core_clk);
                far_on_b <= 1'b1;
            end
        join
        $display("test orientation done");
    endtask

    // far end talks first; the device must hold off until the line is quiet
    task automatic t_contend;
        far_on_b <= 1'b1;
        repeat (2) @(posedge core_clk);
        fork
            frame(1, 16'h0C0F, 12, 12);
            begin
                repeat (30) @(posedge core_clk);
                frame(0, 16'h0A53, 12, 12);
            end
        join
        $display("test shared line turn taking done");
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        end_of_test();
    end

    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_reset();
        t_line_a();
        t_orient();
        t_contend();
        end_of_test();
    end
endmodule // pd_bmc_phy_link_tb

// ==== tb/pdl_link_sva.sv ====
// concurrent checks on the shared configuration lines of the coded link
module pdl_link_sva #(
    parameter int HALF = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic config_line_a_out,
    input wire logic config_line_a_oe,
    input wire logic config_line_b_out,
    input wire logic config_line_b_oe,
    input wire logic far_out,
    input wire logic far_oe,
    input wire logic far_on_b
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // run length of each talker
    // ****************************************************************
    logic dev_oe;
    logic dev_out;
    logic prev_d;
    logic prev_f;
    int   run_d;
    int   run_f;

    // device drives at most one line, so a mux gives its single talker view
    assign dev_oe  = config_line_a_oe | config_line_b_oe;
    assign dev_out = config_line_b_oe ? config_line_b_out : config_line_a_out;

    // cycles since the last toggle; zero while released
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prev_d <= 1'b1;
            prev_f <= 1'b1;
            run_d  <= 0;
            run_f  <= 0;
        end else begin
            prev_d <= dev_out;
            prev_f <= far_out;
            run_d  <= !dev_oe ? 0 : (dev_out != prev_d) ? 1 : run_d + 1;
            run_f  <= !far_oe ? 0 : (far_out != prev_f) ? 1 : run_f + 1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // ****************************************************************
    // line ownership and framing
    // ****************************************************************
    single_line_a: assert property (!(config_line_a_oe && config_line_b_oe))
        else $error("device drives both lines");
    one_talker_a: assert property (!(far_oe && (far_on_b ? config_line_b_oe : config_line_a_oe)))
        else $error("two talkers on one line");
    lead_low_a: assert property ($rose(dev_oe) |-> !dev_out)
        else $error("device preamble not opened low");
    lead_low_far_a: assert property ($rose(far_oe) |-> !far_out)
        else $error("far preamble not opened low");
    edge_space_a: assert property ((dev_oe && $past(dev_oe) && dev_out != prev_d)
        |-> (run_d == HALF || run_d == 2 * HALF))
        else $error("device edge spacing off");
    edge_space_far_a: assert property ((far_oe && $past(far_oe) && far_out != prev_f)
        |-> (run_f == HALF || run_f == 2 * HALF))
        else $error("far edge spacing off");
    run_bound_a: assert property (dev_oe |-> run_d <= 2 * HALF)
        else $error("device bit without opening edge");
    closing_edge_a: assert property ($fell(dev_oe) |-> $past(run_d) <= HALF)
        else $error("device released without closing edge");
    closing_far_a: assert property ($fell(far_oe) |-> $past(run_f) <= HALF)
        else $error("far released without closing edge");
endmodule // pdl_link_sva
